// File: logic/ltd_cfg.svh
// Constants of the logical and transfer datapath: SFR addresses,
// field positions and reset values. Included by the package and the core.
`ifndef LTD_CFG_SVH
`define LTD_CFG_SVH

`define LTD_SFR_BASE     8'h80
`define LTD_ADDR_ACC     8'hE0
`define LTD_ADDR_PSW     8'hD0
`define LTD_ADDR_SP      8'h81
`define LTD_ADDR_DPL     8'h82
`define LTD_ADDR_DPH     8'h83
`define LTD_PSW_CY       7
`define LTD_PSW_BANK_HI  4
`define LTD_PSW_BANK_LO  3
`define LTD_ACC_RESET    8'h00
`define LTD_PSW_RESET    8'h00
`define LTD_SP_RESET     8'h07
`define LTD_DATA_POINTER_RESET   16'h0000

`endif

// File: logic/ltd_pkg.sv
// Types shared by the datapath and its bench: operation and addressing mode codes.
// Assumes ltd_cfg.svh is on the include path.
`include "ltd_cfg.svh"

package ltd_pkg;

	typedef enum logic [4:0] {
		OP_AND_LOGIC_ACC,
		OP_AND_LOGIC_DIR_ACC,
		OP_AND_LOGIC_DIR_IMM,
		OP_OR_LOGIC_ACC,
		OP_OR_LOGIC_DIR_ACC,
		OP_OR_LOGIC_DIR_IMM,
		OP_XOR_LOGIC_ACC,
		OP_XOR_LOGIC_DIR_ACC,
		OP_XOR_LOGIC_DIR_IMM,
		OP_CLEAR_ACC,
		OP_COMPLEMENT_ACC,
		OP_ROTATE_LEFT,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT,
		OP_ROTATE_RIGHT_CARRY,
		OP_NIBBLE_SWAP,
		OP_MOVE_ACC_SRC,
		OP_MOVE_DST_ACC,
		OP_MOVE_BYTE,
		OP_PUSH,
		OP_POP,
		OP_LOAD_DATA_POINTER,
		OP_EXCHANGE_BYTE,
		OP_EXCHANGE_LOW_DIGIT
	} ltd_op_type;

	typedef enum logic [1:0] {
		MODE_DIRECT,
		MODE_INDIRECT,
		MODE_REGISTER,
		MODE_IMMEDIATE
	} ltd_mode_type;

endpackage

// File: logic/ltd_datapath.sv
// Execution datapath for logical and internal data-transfer operations.
// Assumes the decoder presents one operation per cycle with its operands.
//
// Summary of operation
// RL1: Logic ops combine each bit independently
// RL2: Accumulator forms take any addressing mode
// RL3: Byte forms direct only, accumulator unchanged
// RL4: XOR with all ones inverts port
// RL5: Rotate left, MSB into LSB
// RL6: Rotate right, LSB into MSB
// RL7: Rotate left through carry
// RL8: Rotate right through carry
// RL9: Swap accumulator nibbles
// RL10: Clear or complement accumulator
// RL11: General move bypasses the accumulator
// RL12: Upper RAM indirect only; direct selects SFR
// RL13: SFRs by direct addressing only
// RL14: Push increments pointer, then writes
// RL15: Pop reads, writes, then decrements
// RL16: Push/pop direct operand, stack indirect
// RL17: Load 16-bit data pointer at once
// RL18: Exchange swaps accumulator and byte
// RL19: Digit exchange swaps low nibbles only
// RL20: Indirect through R0, R1 or pointer
// RL21: Register bank chosen by status bits
`timescale 1ns/1ps
`include "ltd_cfg.svh"

module ltd_datapath
	import ltd_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic         cmdValid,
	input  wire ltd_op_type   cmdOp,
	input  wire ltd_mode_type cmdMode,
	input  wire logic [7:0]   cmdAddr,
	input  wire logic [2:0]   cmdReg,
	input  wire logic [7:0]   cmdData,
	input  wire logic [7:0]   cmdSrcAddr,
	input  wire logic [15:0]  cmdData16,
	output logic [7:0]        accOut,
	output logic [7:0]        pswOut,
	output logic [7:0]        spOut,
	output logic [15:0]       dptrOut,
	output logic              done,
	output logic              error
);

	logic [7:0]  ram [0:255];
	logic [7:0]  sfrMem [0:127];
	logic [7:0]  acc_r;
	logic [7:0]  psw_r;
	logic [7:0]  sp_r;
	logic [15:0] data_pointer_r;
	logic        done_r;
	logic        error_r;

	logic        execOk;
	logic        locSfr;
	logic [7:0]  locAddr;
	logic [7:0]  opVal;
	logic [7:0]  indPtr;
	logic [1:0]  bank;
	logic        wrEn;
	logic        wrSfr;
	logic [7:0]  wrAddr;
	logic [7:0]  wrData;
	logic        accWr;
	logic [7:0]  accVal;
	logic        cyWr;
	logic        cyVal;
	logic        spWr;
	logic [7:0]  spVal;
	logic        dptrWr;

	function automatic logic modeLegal(ltd_op_type op, ltd_mode_type mode);
		unique case (op)
			OP_AND_LOGIC_DIR_ACC, OP_AND_LOGIC_DIR_IMM, OP_OR_LOGIC_DIR_ACC, OP_OR_LOGIC_DIR_IMM,
			OP_XOR_LOGIC_DIR_ACC, OP_XOR_LOGIC_DIR_IMM, OP_PUSH, OP_POP:
				return mode == MODE_DIRECT;
			OP_MOVE_DST_ACC, OP_MOVE_BYTE, OP_EXCHANGE_BYTE:
				return mode != MODE_IMMEDIATE;
			OP_EXCHANGE_LOW_DIGIT:
				return mode == MODE_INDIRECT;
			default:
				return 1'b1;
		endcase
	endfunction

	// Special registers live in flops; the rest of SFR space is plain storage
	function automatic logic [7:0] readLoc(logic isSfr, logic [7:0] addr);
		if (!isSfr)
			return ram[addr];
		unique case (addr)
			`LTD_ADDR_ACC: return acc_r;
			`LTD_ADDR_PSW: return psw_r;
			`LTD_ADDR_SP:  return sp_r;
			`LTD_ADDR_DPL: return data_pointer_r[7:0];
			`LTD_ADDR_DPH: return data_pointer_r[15:8];
			default:       return sfrMem[addr[6:0]];
		endcase
	endfunction

	function automatic logic isSpecial(logic [7:0] addr);
		return addr == `LTD_ADDR_ACC || addr == `LTD_ADDR_PSW || addr == `LTD_ADDR_SP ||
			addr == `LTD_ADDR_DPL || addr == `LTD_ADDR_DPH;
	endfunction

	assign bank   = psw_r[`LTD_PSW_BANK_HI:`LTD_PSW_BANK_LO];
	// A process, not an assign, so that a store to the pointer byte is seen at once
	always_comb begin
		indPtr = ram[{3'h0, bank, 2'h0, cmdReg[0]}]; // RL20 RL21
	end

	// Operand location; indirect never reaches SFR space
	always_comb begin
		locSfr  = 1'b0;
		locAddr = cmdAddr;
		unique case (cmdMode)
			MODE_DIRECT: begin
				locSfr = cmdAddr >= `LTD_SFR_BASE; // RL12 RL13
			end
			MODE_INDIRECT: begin
				locAddr = indPtr; // RL12 RL13 RL20
			end
			MODE_REGISTER: begin
				locAddr = {3'h0, bank, cmdReg}; // RL21
			end
			MODE_IMMEDIATE: begin
				locAddr = cmdAddr;
			end
		endcase
	end

	// Must follow stores behind an unchanged address, hence not an assign
	always_comb begin
		opVal = (cmdMode == MODE_IMMEDIATE) ? cmdData : readLoc(locSfr, locAddr); // RL2
	end
	assign execOk = cmdValid && modeLegal(cmdOp, cmdMode); // RL3 RL16 RL19

	// Enables carry the legality check; the case forms the values and the gated data pointer enable
	always_comb begin
		wrEn   = execOk && cmdOp inside {OP_AND_LOGIC_DIR_ACC, OP_AND_LOGIC_DIR_IMM, OP_OR_LOGIC_DIR_ACC,
			OP_OR_LOGIC_DIR_IMM, OP_XOR_LOGIC_DIR_ACC, OP_XOR_LOGIC_DIR_IMM, OP_MOVE_DST_ACC, OP_MOVE_BYTE,
			OP_PUSH, OP_POP, OP_EXCHANGE_BYTE, OP_EXCHANGE_LOW_DIGIT};
		wrSfr  = locSfr;
		wrAddr = locAddr;
		wrData = 8'h00;
		accWr  = execOk && cmdOp inside {OP_AND_LOGIC_ACC, OP_OR_LOGIC_ACC, OP_XOR_LOGIC_ACC, OP_CLEAR_ACC,
			OP_COMPLEMENT_ACC, OP_ROTATE_LEFT, OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_CARRY,
			OP_NIBBLE_SWAP, OP_MOVE_ACC_SRC, OP_EXCHANGE_BYTE, OP_EXCHANGE_LOW_DIGIT}; // RL3 RL11
		accVal = acc_r;
		cyWr   = execOk && cmdOp inside {OP_ROTATE_LEFT_CARRY, OP_ROTATE_RIGHT_CARRY}; // RL7 RL8
		cyVal  = psw_r[`LTD_PSW_CY];
		spWr   = execOk && cmdOp inside {OP_PUSH, OP_POP}; // RL14 RL15
		spVal  = sp_r;
		dptrWr = 1'b0;
		unique case (cmdOp)
			OP_AND_LOGIC_ACC:      accVal = acc_r & opVal; // RL1 RL2
			OP_OR_LOGIC_ACC:       accVal = acc_r | opVal; // RL1 RL2
			OP_XOR_LOGIC_ACC:      accVal = acc_r ^ opVal; // RL1 RL2
			OP_AND_LOGIC_DIR_ACC:  wrData = opVal & acc_r; // RL1 RL3
			OP_OR_LOGIC_DIR_ACC:   wrData = opVal | acc_r; // RL1 RL3
			OP_XOR_LOGIC_DIR_ACC:  wrData = opVal ^ acc_r; // RL1 RL3
			OP_AND_LOGIC_DIR_IMM:  wrData = readLoc(locSfr, locAddr) & cmdData; // RL1 RL3
			OP_OR_LOGIC_DIR_IMM:   wrData = readLoc(locSfr, locAddr) | cmdData; // RL1 RL3
			OP_XOR_LOGIC_DIR_IMM:  wrData = readLoc(locSfr, locAddr) ^ cmdData; // RL1 RL3 RL4
			OP_CLEAR_ACC:          accVal = 8'h00; // RL10
			OP_COMPLEMENT_ACC:     accVal = ~acc_r; // RL10
			OP_ROTATE_LEFT:        accVal = {acc_r[6:0], acc_r[7]}; // RL5
			OP_ROTATE_RIGHT:       accVal = {acc_r[0], acc_r[7:1]}; // RL6
			OP_ROTATE_LEFT_CARRY: begin
				accVal = {acc_r[6:0], psw_r[`LTD_PSW_CY]}; // RL7
				cyVal  = acc_r[7];
			end
			OP_ROTATE_RIGHT_CARRY: begin
				accVal = {psw_r[`LTD_PSW_CY], acc_r[7:1]}; // RL8
				cyVal  = acc_r[0];
			end
			OP_NIBBLE_SWAP:        accVal = {acc_r[3:0], acc_r[7:4]}; // RL9
			OP_MOVE_ACC_SRC:       accVal = opVal;
			OP_MOVE_DST_ACC:       wrData = acc_r;
			OP_MOVE_BYTE:          wrData = readLoc(cmdSrcAddr >= `LTD_SFR_BASE, cmdSrcAddr); // RL11
			OP_PUSH: begin
				spVal  = sp_r + 8'h01; // RL14
				wrSfr  = 1'b0; // RL16
				wrAddr = spVal; // RL14 RL20
				wrData = opVal;
			end
			OP_POP: begin
				spVal  = sp_r - 8'h01; // RL15
				wrData = ram[sp_r]; // RL15 RL16 RL20
			end
			OP_LOAD_DATA_POINTER:  dptrWr = execOk; // RL17
			OP_EXCHANGE_BYTE: begin
				accVal = opVal; // RL18
				wrData = acc_r;
			end
			OP_EXCHANGE_LOW_DIGIT: begin
				accVal = {acc_r[7:4], opVal[3:0]}; // RL19
				wrData = {opVal[7:4], acc_r[3:0]};
			end
		endcase
	end

	// A byte written to a special register's address overrides the implied update
	always_ff @(posedge clock) begin
		if (!rst_n)
			acc_r <= `LTD_ACC_RESET;
		else if (wrEn && wrSfr && wrAddr == `LTD_ADDR_ACC)
			acc_r <= wrData;
		else if (accWr)
			acc_r <= accVal;
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			psw_r <= `LTD_PSW_RESET;
		else if (wrEn && wrSfr && wrAddr == `LTD_ADDR_PSW)
			psw_r <= wrData;
		else if (cyWr)
			psw_r[`LTD_PSW_CY] <= cyVal; // RL7 RL8
	end

	// Popping into the pointer itself keeps the popped value, not the decrement
	always_ff @(posedge clock) begin
		if (!rst_n)
			sp_r <= `LTD_SP_RESET;
		else if (wrEn && wrSfr && wrAddr == `LTD_ADDR_SP)
			sp_r <= wrData;
		else if (spWr)
			sp_r <= spVal; // RL14 RL15
	end

	always_ff @(posedge clock) begin
		if (!rst_n)
			data_pointer_r <= `LTD_DATA_POINTER_RESET;
		else if (dptrWr)
			data_pointer_r <= cmdData16; // RL17
		else if (wrEn && wrSfr && wrAddr == `LTD_ADDR_DPL)
			data_pointer_r[7:0] <= wrData;
		else if (wrEn && wrSfr && wrAddr == `LTD_ADDR_DPH)
			data_pointer_r[15:8] <= wrData;
	end

	// Storage carries no reset; contents are undefined until written
	always_ff @(posedge clock) begin
		if (wrEn && !wrSfr)
			ram[wrAddr] <= wrData;
	end

	always_ff @(posedge clock) begin
		if (wrEn && wrSfr && !isSpecial(wrAddr))
			sfrMem[wrAddr[6:0]] <= wrData; // RL4 RL13
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			done_r  <= 1'b0;
			error_r <= 1'b0;
		end else begin
			done_r  <= execOk;
			error_r <= cmdValid && !execOk;
		end
	end

	assign accOut  = acc_r;
	assign pswOut  = psw_r;
	assign spOut   = sp_r;
	assign dptrOut = data_pointer_r;
	assign done    = done_r;
	assign error   = error_r;

	// Helper state for the checks below
	ltd_op_type  lastOp_r;
	logic [7:0]  lastAcc_r;
	logic [7:0]  lastVal_r;
	logic        lastCy_r;
	logic [7:0]  lastSp_r;
	logic        lastWrAcc_r;

	always_ff @(posedge clock) begin
		lastOp_r    <= cmdOp;
		lastAcc_r   <= acc_r;
		lastVal_r   <= opVal;
		lastCy_r    <= psw_r[`LTD_PSW_CY];
		lastSp_r    <= sp_r;
		lastWrAcc_r <= wrEn && wrSfr && (isSpecial(wrAddr));
	end

	AST_AND_ACC: assert property (@(posedge clock) disable iff (!rst_n) // RL1
		done_r && lastOp_r == OP_AND_LOGIC_ACC |-> acc_r == (lastAcc_r & lastVal_r))
		else $error("accumulator AND result wrong");

	AST_BYTE_FORM_KEEPS_ACC: assert property (@(posedge clock) disable iff (!rst_n) // RL3
		done_r && !lastWrAcc_r && lastOp_r inside {OP_AND_LOGIC_DIR_ACC, OP_OR_LOGIC_DIR_IMM, OP_AND_LOGIC_DIR_IMM,
		OP_XOR_LOGIC_DIR_IMM, OP_XOR_LOGIC_DIR_ACC, OP_OR_LOGIC_DIR_ACC} |-> acc_r == lastAcc_r)
		else $error("byte-destination logic op altered accumulator");

	AST_XOR_INVERT: assert property (@(posedge clock) disable iff (!rst_n) // RL4
		execOk && cmdOp == OP_XOR_LOGIC_DIR_IMM && cmdData == 8'hFF |-> wrEn && wrData == ~opVal)
		else $error("XOR with all ones did not invert");

	AST_ROTATE_LEFT: assert property (@(posedge clock) disable iff (!rst_n) // RL5
		execOk && cmdOp == OP_ROTATE_LEFT |=> acc_r == {lastAcc_r[6:0], lastAcc_r[7]})
		else $error("rotate left wrong");

	AST_ROTATE_RIGHT: assert property (@(posedge clock) disable iff (!rst_n) // RL6
		execOk && cmdOp == OP_ROTATE_RIGHT |=> acc_r == {lastAcc_r[0], lastAcc_r[7:1]})
		else $error("rotate right wrong");

	AST_ROTATE_LEFT_CARRY: assert property (@(posedge clock) disable iff (!rst_n) // RL7
		execOk && cmdOp == OP_ROTATE_LEFT_CARRY |=>
		{psw_r[`LTD_PSW_CY], acc_r} == {lastAcc_r, lastCy_r})
		else $error("rotate left through carry wrong");

	AST_ROTATE_RIGHT_CARRY: assert property (@(posedge clock) disable iff (!rst_n) // RL8
		execOk && cmdOp == OP_ROTATE_RIGHT_CARRY |=>
		{acc_r, psw_r[`LTD_PSW_CY]} == {lastCy_r, lastAcc_r})
		else $error("rotate right through carry wrong");

	AST_NIBBLE_SWAP: assert property (@(posedge clock) disable iff (!rst_n) // RL9
		execOk && cmdOp == OP_NIBBLE_SWAP ##1 done_r |-> acc_r == {lastAcc_r[3:0], lastAcc_r[7:4]})
		else $error("nibble swap wrong");

	AST_CLEAR_ACC: assert property (@(posedge clock) disable iff (!rst_n) // RL10
		execOk && cmdOp == OP_CLEAR_ACC |=> acc_r == 8'h00 && done_r)
		else $error("clear did not zero accumulator");

	AST_INDIRECT_NOT_SFR: assert property (@(posedge clock) disable iff (!rst_n) // RL13
		cmdMode == MODE_INDIRECT |-> !locSfr && locAddr == indPtr)
		else $error("indirect access reached SFR space");

	AST_DIRECT_UPPER_SFR: assert property (@(posedge clock) disable iff (!rst_n) // RL12
		cmdMode == MODE_DIRECT |-> locSfr == cmdAddr[7])
		else $error("direct upper address not mapped to SFR");

	AST_PUSH_SP: assert property (@(posedge clock) disable iff (!rst_n) // RL14
		execOk && cmdOp == OP_PUSH && !(locSfr && cmdAddr == `LTD_ADDR_SP) |=> sp_r == lastSp_r + 8'h01)
		else $error("push did not increment stack pointer");

	AST_POP_SP: assert property (@(posedge clock) disable iff (!rst_n) // RL15
		execOk && cmdOp == OP_POP && !(locSfr && cmdAddr == `LTD_ADDR_SP) |=> sp_r == lastSp_r - 8'h01)
		else $error("pop did not decrement stack pointer");

	AST_STACK_DIRECT_ONLY: assert property (@(posedge clock) disable iff (!rst_n) // RL16
		cmdValid && cmdOp inside {OP_PUSH, OP_POP} && cmdMode != MODE_DIRECT |=> error_r && !done_r)
		else $error("push or pop accepted non-direct operand");

	AST_LOAD_DATA_POINTER: assert property (@(posedge clock) disable iff (!rst_n) // RL17
		execOk && cmdOp == OP_LOAD_DATA_POINTER |=> data_pointer_r == $past(cmdData16))
		else $error("data pointer load wrong");

	AST_EXCHANGE_LOW_DIGIT: assert property (@(posedge clock) disable iff (!rst_n) // RL19
		execOk && cmdOp == OP_EXCHANGE_LOW_DIGIT |-> wrData == {opVal[7:4], acc_r[3:0]} ##1
		acc_r == {lastAcc_r[7:4], lastVal_r[3:0]})
		else $error("digit exchange wrong");

endmodule

// File: tb/ltd_testbench.sv
// Self-checking bench for the logical and transfer datapath.
// Assumes ltd_pkg and ltd_cfg.svh are compiled first; drives the command port directly.
`timescale 1ns/1ps
`include "ltd_cfg.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
	$display("wrong value %s expected %h seen %h", nm, exp, got); end end

module testbench
	import ltd_pkg::*;
;
	typedef struct {
		ltd_op_type op;
		logic [7:0] a;
		logic [7:0] d;
		logic       cy;
		logic [7:0] expA;
		logic       expCy;
	} ltd_row_type;

	logic         clock = 1'b0;
	logic         rst_n = 1'b0;
	logic         cmdValid = 1'b0;
	ltd_op_type   cmdOp = OP_CLEAR_ACC;
	ltd_mode_type cmdMode = MODE_DIRECT;
	logic [7:0]   cmdAddr = 8'h00;
	logic [2:0]   cmdReg = 3'h0;
	logic [7:0]   cmdData = 8'h00;
	logic [7:0]   cmdSrcAddr = 8'h00;
	logic [15:0]  cmdData16 = 16'h0000;
	logic [7:0]   accOut;
	logic [7:0]   pswOut;
	logic [7:0]   spOut;
	logic [15:0]  dptrOut;
	logic         done;
	logic         error;
	int           err_count = 0;
	int           n_tests = 0;
	int           cycles = 0;

	ltd_row_type rows [15] = '{
		'{OP_AND_LOGIC_ACC, 8'h35, 8'h53, 1'b0, 8'h11, 1'b0},
		'{OP_OR_LOGIC_ACC, 8'h35, 8'h53, 1'b1, 8'h77, 1'b1},
		'{OP_XOR_LOGIC_ACC, 8'h35, 8'h53, 1'b0, 8'h66, 1'b0},
		'{OP_CLEAR_ACC, 8'hA5, 8'h00, 1'b0, 8'h00, 1'b0},
		'{OP_COMPLEMENT_ACC, 8'hA5, 8'h00, 1'b1, 8'h5A, 1'b1},
		'{OP_ROTATE_LEFT, 8'h85, 8'h00, 1'b0, 8'h0B, 1'b0},
		'{OP_ROTATE_LEFT, 8'h40, 8'h00, 1'b1, 8'h80, 1'b1},
		'{OP_ROTATE_RIGHT, 8'h85, 8'h00, 1'b0, 8'hC2, 1'b0},
		'{OP_ROTATE_RIGHT, 8'h02, 8'h00, 1'b1, 8'h01, 1'b1},
		'{OP_ROTATE_LEFT_CARRY, 8'h85, 8'h00, 1'b0, 8'h0A, 1'b1},
		'{OP_ROTATE_LEFT_CARRY, 8'h05, 8'h00, 1'b1, 8'h0B, 1'b0},
		'{OP_ROTATE_RIGHT_CARRY, 8'h85, 8'h00, 1'b0, 8'h42, 1'b1},
		'{OP_ROTATE_RIGHT_CARRY, 8'h04, 8'h00, 1'b1, 8'h82, 1'b0},
		'{OP_NIBBLE_SWAP, 8'hA5, 8'h00, 1'b0, 8'h5A, 1'b0},
		'{OP_NIBBLE_SWAP, 8'h3C, 8'h00, 1'b1, 8'hC3, 1'b1}
	};

	ltd_datapath i_dut (
		.clock      (clock),
		.rst_n      (rst_n),
		.cmdValid   (cmdValid),
		.cmdOp      (cmdOp),
		.cmdMode    (cmdMode),
		.cmdAddr    (cmdAddr),
		.cmdReg     (cmdReg),
		.cmdData    (cmdData),
		.cmdSrcAddr (cmdSrcAddr),
		.cmdData16  (cmdData16),
		.accOut     (accOut),
		.pswOut     (pswOut),
		.spOut      (spOut),
		.dptrOut    (dptrOut),
		.done       (done),
		.error      (error)
	);

	always #4 clock = ~clock;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Generous ceiling; the whole run needs a few hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			$display("timeout after %0d cycles", cycles);
			conclude();
		end
	end

	// Entered 1 ns after an edge; with hold the command stays valid for the next call
	task automatic exec(input ltd_op_type op, input ltd_mode_type md, input logic [7:0] adr,
		input logic [2:0] rg, input logic [7:0] dat, input bit bad = 1'b0, input bit hold = 1'b0);
		cmdOp = op;
		cmdMode = md;
		cmdAddr = adr;
		cmdReg = rg;
		cmdData = dat;
		if (cmdValid !== 1'b1) cmdValid = 1'b1;
		@(posedge clock);
		#1;
		`CHK("done", !bad, done)
		`CHK("error", bad, error)
		if (!hold) begin
			cmdValid = 1'b0;
			@(posedge clock);
			#1;
			`CHK("done idle", 1'b0, done)
		end
	endtask

	task automatic loadA(input logic [7:0] v);
		exec(OP_MOVE_ACC_SRC, MODE_IMMEDIATE, 8'h00, 3'h0, v);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		loadA(v);
		exec(OP_MOVE_DST_ACC, MODE_DIRECT, a, 3'h0, 8'h00);
	endtask

	task automatic rd(input ltd_mode_type md, input logic [7:0] a, input logic [7:0] exp);
		exec(OP_MOVE_ACC_SRC, md, a, a[2:0], 8'h00);
		`CHK("byte read", exp, accOut)
	endtask

	initial begin
		repeat (8) @(posedge clock);
		#1;
		`CHK("acc reset", `LTD_ACC_RESET, accOut)
		`CHK("psw reset", `LTD_PSW_RESET, pswOut)
		`CHK("sp reset", `LTD_SP_RESET, spOut)
		`CHK("data_pointer reset", `LTD_DATA_POINTER_RESET, dptrOut)
		rst_n = 1'b1;
		$display("test reset done");

		foreach (rows[i]) begin
			wr(`LTD_ADDR_PSW, {rows[i].cy, 7'h00});
			loadA(rows[i].a);
			exec(rows[i].op, MODE_IMMEDIATE, 8'h00, 3'h0, rows[i].d);
			`CHK("acc", rows[i].expA, accOut)
			`CHK("carry", rows[i].expCy, pswOut[`LTD_PSW_CY])
		end
		$display("test accumulator table done");

		wr(8'h30, 8'h3C);
		wr(8'h01, 8'h30);
		wr(8'h06, 8'h0F);
		wr(8'h16, 8'hF0);
		loadA(8'hFF);
		exec(OP_AND_LOGIC_ACC, MODE_DIRECT, 8'h30, 3'h0, 8'h00);
		`CHK("and direct", 8'h3C, accOut)
		loadA(8'hF3);
		exec(OP_XOR_LOGIC_ACC, MODE_INDIRECT, 8'h00, 3'h1, 8'h00);
		`CHK("xor indirect", 8'hCF, accOut)
		loadA(8'h00);
		exec(OP_OR_LOGIC_ACC, MODE_REGISTER, 8'h00, 3'h6, 8'h00);
		`CHK("or bank0", 8'h0F, accOut)
		wr(`LTD_ADDR_PSW, 8'h10);
		loadA(8'h00);
		exec(OP_OR_LOGIC_ACC, MODE_REGISTER, 8'h00, 3'h6, 8'h00);
		`CHK("or bank2", 8'hF0, accOut)
		wr(`LTD_ADDR_PSW, 8'h00);
		$display("test addressing modes done");

		wr(8'h40, 8'h55);
		loadA(8'h0F);
		exec(OP_XOR_LOGIC_DIR_ACC, MODE_DIRECT, 8'h40, 3'h0, 8'h00);
		`CHK("acc kept", 8'h0F, accOut)
		rd(MODE_DIRECT, 8'h40, 8'h5A);
		exec(OP_AND_LOGIC_DIR_IMM, MODE_DIRECT, 8'h40, 3'h0, 8'hF0);
		loadA(8'h03);
		exec(OP_OR_LOGIC_DIR_ACC, MODE_DIRECT, 8'h40, 3'h0, 8'h00);
		rd(MODE_DIRECT, 8'h40, 8'h53);
		exec(OP_AND_LOGIC_DIR_IMM, MODE_INDIRECT, 8'h40, 3'h0, 8'h00, 1'b1);
		rd(MODE_DIRECT, 8'h40, 8'h53);
		wr(8'h90, 8'hA5);
		exec(OP_XOR_LOGIC_DIR_IMM, MODE_DIRECT, 8'h90, 3'h0, 8'hFF);
		rd(MODE_DIRECT, 8'h90, 8'h5A);
		$display("test byte forms done");

		wr(8'h50, 8'hC3);
		loadA(8'h77);
		cmdSrcAddr = 8'h50;
		exec(OP_MOVE_BYTE, MODE_DIRECT, 8'h51, 3'h0, 8'h00);
		`CHK("acc untouched", 8'h77, accOut)
		rd(MODE_DIRECT, 8'h51, 8'hC3);
		// Indirect at 90h must land in upper RAM, not the port register
		wr(8'h00, 8'h90);
		loadA(8'h11);
		exec(OP_MOVE_DST_ACC, MODE_INDIRECT, 8'h00, 3'h0, 8'h00);
		rd(MODE_DIRECT, 8'h90, 8'h5A);
		rd(MODE_INDIRECT, 8'h00, 8'h11);
		wr(8'h00, `LTD_ADDR_ACC);
		loadA(8'h22);
		exec(OP_MOVE_DST_ACC, MODE_INDIRECT, 8'h00, 3'h0, 8'h00);
		loadA(8'h00);
		rd(MODE_INDIRECT, 8'h00, 8'h22);
		$display("test memory spaces done");

		wr(8'h30, 8'hAB);
		exec(OP_PUSH, MODE_DIRECT, 8'h30, 3'h0, 8'h00);
		`CHK("sp push", 8'h08, spOut)
		rd(MODE_DIRECT, 8'h08, 8'hAB);
		wr(`LTD_ADDR_SP, 8'h7F);
		exec(OP_PUSH, MODE_DIRECT, 8'h30, 3'h0, 8'h00);
		`CHK("sp upper", 8'h80, spOut)
		wr(8'h00, 8'h80);
		rd(MODE_INDIRECT, 8'h00, 8'hAB);
		exec(OP_POP, MODE_DIRECT, 8'h31, 3'h0, 8'h00);
		`CHK("sp pop", 8'h7F, spOut)
		rd(MODE_DIRECT, 8'h31, 8'hAB);
		exec(OP_PUSH, MODE_IMMEDIATE, 8'h30, 3'h0, 8'h00, 1'b1);
		exec(OP_POP, MODE_INDIRECT, 8'h31, 3'h0, 8'h00, 1'b1);
		`CHK("sp refused", 8'h7F, spOut)
		$display("test stack done");

		cmdData16 = 16'hA55A;
		exec(OP_LOAD_DATA_POINTER, MODE_IMMEDIATE, 8'h00, 3'h0, 8'h00);
		`CHK("data_pointer", 16'hA55A, dptrOut)
		rd(MODE_DIRECT, `LTD_ADDR_DPL, 8'h5A);
		rd(MODE_DIRECT, `LTD_ADDR_DPH, 8'hA5);
		wr(8'h60, 8'hC3);
		loadA(8'h3C);
		exec(OP_EXCHANGE_BYTE, MODE_DIRECT, 8'h60, 3'h0, 8'h00);
		`CHK("xch acc", 8'hC3, accOut)
		rd(MODE_DIRECT, 8'h60, 8'h3C);
		exec(OP_EXCHANGE_BYTE, MODE_IMMEDIATE, 8'h60, 3'h0, 8'h00, 1'b1);
		wr(8'h61, 8'hA7);
		wr(8'h01, 8'h61);
		loadA(8'h5C);
		exec(OP_EXCHANGE_LOW_DIGIT, MODE_INDIRECT, 8'h00, 3'h1, 8'h00);
		`CHK("exchange_low_digit acc", 8'h57, accOut)
		rd(MODE_DIRECT, 8'h61, 8'hAC);
		exec(OP_EXCHANGE_LOW_DIGIT, MODE_DIRECT, 8'h61, 3'h0, 8'h00, 1'b1);
		$display("test exchange done");

		// Back to back: each command sees the previous result
		exec(OP_MOVE_ACC_SRC, MODE_IMMEDIATE, 8'h00, 3'h0, 8'hF0, 1'b0, 1'b1);
		exec(OP_XOR_LOGIC_ACC, MODE_IMMEDIATE, 8'h00, 3'h0, 8'h0F, 1'b0, 1'b1);
		`CHK("b2b xor", 8'hFF, accOut)
		exec(OP_ROTATE_RIGHT, MODE_IMMEDIATE, 8'h00, 3'h0, 8'h00, 1'b0, 1'b1);
		exec(OP_COMPLEMENT_ACC, MODE_IMMEDIATE, 8'h00, 3'h0, 8'h00);
		`CHK("b2b cpl", 8'h00, accOut)
		$display("test back to back done");

		// Mid-run reset with a command held valid: nothing of it may land
		loadA(8'hA5);
		rst_n = 1'b0;
		cmdOp = OP_COMPLEMENT_ACC;
		cmdValid = 1'b1;
		repeat (2) @(posedge clock);
		#1;
		`CHK("acc rearm", `LTD_ACC_RESET, accOut)
		`CHK("psw rearm", `LTD_PSW_RESET, pswOut)
		`CHK("sp rearm", `LTD_SP_RESET, spOut)
		`CHK("data_pointer rearm", `LTD_DATA_POINTER_RESET, dptrOut)
		`CHK("done rearm", 1'b0, done)
		`CHK("error rearm", 1'b0, error)
		rst_n = 1'b1;
		exec(OP_COMPLEMENT_ACC, MODE_IMMEDIATE, 8'h00, 3'h0, 8'h00);
		`CHK("first after reset", 8'hFF, accOut)
		$display("test mid-run reset done");
		conclude();
	end
endmodule
